// ==== core/csch_pkg.sv ====
package csch_pkg;

   // ---------------------------------------------------------------
   // Field widths
   // ---------------------------------------------------------------
   localparam int HOUR_W  = 5;
   localparam int MIN_W   = 6;
   localparam int SEC_W   = 6;
   localparam int YEAR_W  = 12;
   localparam int MONTH_W = 4;
   localparam int DAY_W   = 5;
   localparam int WDAY_W  = 3;
   localparam int MASK_W  = 7;
   localparam int NUM_SCHED = 2;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [HOUR_W-1:0]  DEF_HOUR  = 5'h00;
   localparam logic [MIN_W-1:0]   DEF_MIN   = 6'h00;
   localparam logic [SEC_W-1:0]   DEF_SEC   = 6'h00;
   localparam logic [YEAR_W-1:0]  DEF_YEAR  = 12'h7d0;
   localparam logic [MONTH_W-1:0] DEF_MONTH = 4'h0;
   localparam logic [DAY_W-1:0]   DEF_DAY   = 5'h00;
   // Bit 0 is Monday, bit 6 is Sunday.
   localparam logic [MASK_W-1:0]  DEF_MASK  = 7'h7f;

   typedef struct packed {
      logic [HOUR_W-1:0] hour;
      logic [MIN_W-1:0]  minute;
      logic [SEC_W-1:0]  second;
   } csch_time_s;

   typedef struct packed {
      logic [YEAR_W-1:0]  year;
      logic [MONTH_W-1:0] month;
      logic [DAY_W-1:0]   day;
   } csch_date_s;

   typedef struct packed {
      csch_time_s        on_time;
      csch_time_s        off_time;
      csch_date_s        on_date;
      csch_date_s        off_date;
      logic [MASK_W-1:0] weekday_mask;
   } csch_cfg_s;

   localparam csch_time_s DEF_TIME = '{hour: DEF_HOUR, minute: DEF_MIN, second: DEF_SEC};
   localparam csch_date_s DEF_DATE = '{year: DEF_YEAR, month: DEF_MONTH, day: DEF_DAY};
   localparam csch_cfg_s  DEF_CFG  = '{on_time: DEF_TIME, off_time: DEF_TIME,
                                       on_date: DEF_DATE, off_date: DEF_DATE,
                                       weekday_mask: DEF_MASK};

endpackage

// ==== core/csch_top.sv ====
// Function
// - Output turns on when time of day reaches the on-time.
// - Output turns off when time of day reaches the off-time.
// - On-date holds output inactive before it; default 2000-00-00.
// - Off-date ends activity for good from that date on.
// - Off-date earlier than on-date never deactivates the output.
// - Seven-day mask, all enabled by default, gates the output.
// - On 0:00:00 off 23:59:59 keeps output on all enabled days.
// - Second identical scheduler with own settings and output.
// - Each output is offered as a routing source for other functions.
`timescale 1ns/1ps
`default_nettype none

module csch_top (
   // Clock and reset
   input  wire logic                            clk_in,
   input  wire logic                            nrst_in,
   // Calendar from the real-time clock
   input  wire logic                            sec_tick_in,
   input  wire csch_pkg::csch_time_s            cal_time_in,
   input  wire csch_pkg::csch_date_s            cal_date_in,
   input  wire logic [csch_pkg::WDAY_W-1:0]     cal_weekday_in,
   // Settings write port
   input  wire logic                            cfg_we_one_in,
   input  wire csch_pkg::csch_cfg_s             cfg_one_in,
   input  wire logic                            cfg_we_two_in,
   input  wire csch_pkg::csch_cfg_s             cfg_two_in,
   // Settings readback
   output var csch_pkg::csch_cfg_s              cfg_one_out,
   output var csch_pkg::csch_cfg_s              cfg_two_out,
   // Scheduled outputs
   output logic                                 sched_out_one_out,
   output logic                                 sched_out_two_out
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_n_ff;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Fields are packed most significant first, so a plain unsigned compare
   // of the keys orders times and dates the way a calendar does. The
   // calendar must deliver binary fields; packed decimal would misorder.
   function automatic logic [16:0] time_key(input csch_pkg::csch_time_s t);
      time_key = {t.hour, t.minute, t.second};
   endfunction

   function automatic logic [20:0] date_key(input csch_pkg::csch_date_s d);
      date_key = {d.year, d.month, d.day};
   endfunction

   // Key of the last second of a day. An off-time equal to it is taken as
   // inclusive, since there is no later second to switch off at.
   function automatic logic [16:0] last_second_key();
      csch_pkg::csch_time_s last;
      last.hour       = 5'h17;
      last.minute     = 6'h3b;
      last.second     = 6'h3b;
      last_second_key = time_key(last);
   endfunction

   // Weekday gate. A code above Sunday is not a valid day and never
   // matches, so a calendar that is not yet set keeps the output off.
   function automatic logic day_enabled(input logic [csch_pkg::MASK_W-1:0] mask,
                                        input logic [csch_pkg::WDAY_W-1:0] wd);
      if (wd < 3'h7) begin
         day_enabled = mask[wd];
      end else begin
         day_enabled = 1'b0;
      end
   endfunction

   // Date gate. Active from the on-date onwards. The off-date ends the
   // activity for good, unless it lies before the on-date, in which case it
   // is ignored and the schedule runs on without end.
   function automatic logic date_window(input csch_pkg::csch_cfg_s  c,
                                        input csch_pkg::csch_date_s d);
      logic [20:0] now_d;
      logic [20:0] on_d;
      logic [20:0] off_d;
      now_d = date_key(d);
      on_d  = date_key(c.on_date);
      off_d = date_key(c.off_date);
      date_window = (now_d >= on_d)
                    && ((off_d < on_d)
                        || (now_d < off_d));
   endfunction

   // Time gate. The on-second is included and the off-second excluded,
   // except for an off-time at the last second of the day, which makes a
   // 0:00:00 to 23:59:59 window cover the whole day. A window whose on-time
   // is later than its off-time wraps past midnight. Equal on and off times
   // give a window of that single second.
   function automatic logic time_window(input csch_pkg::csch_cfg_s  c,
                                        input csch_pkg::csch_time_s t);
      logic [16:0] now_t;
      logic [16:0] on_t;
      logic [16:0] off_t;
      logic        in_win;
      now_t = time_key(t);
      on_t  = time_key(c.on_time);
      off_t = time_key(c.off_time);
      if (on_t <= off_t) begin
         in_win = (now_t >= on_t) && (now_t <= off_t);
      end else begin
         in_win = (now_t >= on_t) || (now_t <= off_t);
      end
      if ((on_t != off_t) && (now_t == off_t) && (off_t != last_second_key())) begin
         in_win = 1'b0;
      end
      time_window = in_win;
   endfunction

   // One scheduler evaluation: returns the output level for this second.
   // All three gates must agree; any one of them alone keeps it off.
   function automatic logic sched_eval(input csch_pkg::csch_cfg_s c,
                                       input csch_pkg::csch_time_s t,
                                       input csch_pkg::csch_date_s d,
                                       input logic [csch_pkg::WDAY_W-1:0] wd);
      logic day_ok;
      logic date_ok;
      logic time_ok;
      day_ok     = day_enabled(c.weekday_mask, wd);
      date_ok    = date_window(c, d);
      time_ok    = time_window(c, t);
      sched_eval = day_ok && date_ok && time_ok;
   endfunction

   // ---------------------------------------------------------------
   // Settings storage
   // ---------------------------------------------------------------
   csch_pkg::csch_cfg_s cfg_ff [csch_pkg::NUM_SCHED];
   csch_pkg::csch_cfg_s nxt_cfg [csch_pkg::NUM_SCHED];

   always_comb begin
      nxt_cfg[0] = cfg_ff[0];
      nxt_cfg[1] = cfg_ff[1];
      if (cfg_we_one_in) begin
         nxt_cfg[0] = cfg_one_in;
      end
      if (cfg_we_two_in) begin
         nxt_cfg[1] = cfg_two_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cfg_ff[0] <= csch_pkg::DEF_CFG;
         cfg_ff[1] <= csch_pkg::DEF_CFG;
      end else begin
         cfg_ff[0] <= nxt_cfg[0];
         cfg_ff[1] <= nxt_cfg[1];
      end
   end

   // ---------------------------------------------------------------
   // Tick evaluation
   // ---------------------------------------------------------------
   // Registering on the tick keeps the outputs glitch-free while settings
   // or the calendar change mid-second; the cost is up to one second lag.
   // A write that lands on the same edge as a tick is seen at the next
   // tick, because the evaluation reads the settings stored before it.
   // Until the first tick after reset both outputs stay low, so a freshly
   // started system never sees a spurious schedule pulse.
   logic [csch_pkg::NUM_SCHED-1:0] out_ff;
   logic [csch_pkg::NUM_SCHED-1:0] nxt_out;

   always_comb begin
      nxt_out = out_ff;
      if (sec_tick_in) begin
         nxt_out[0] = sched_eval(cfg_ff[0], cal_time_in, cal_date_in, cal_weekday_in);
         nxt_out[1] = sched_eval(cfg_ff[1], cal_time_in, cal_date_in, cal_weekday_in);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         out_ff <= '0;
      end else begin
         out_ff <= nxt_out;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Each schedule level leaves as a plain registered signal so that the
   // routing logic outside can pick it as a source for relays, digital
   // outputs or virtual inputs without any further qualification.
   assign sched_out_one_out = out_ff[0];
   assign sched_out_two_out = out_ff[1];
   assign cfg_one_out       = cfg_ff[0];
   assign cfg_two_out       = cfg_ff[1];

endmodule

`default_nettype wire

// ==== dv/csch_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module csch_checker (
   input wire logic                        clk_in,
   input wire logic                        nrst_in,
   input wire logic                        sec_tick_in,
   input wire csch_pkg::csch_time_s        cal_time_in,
   input wire csch_pkg::csch_date_s        cal_date_in,
   input wire logic [csch_pkg::WDAY_W-1:0] cal_weekday_in,
   input wire csch_pkg::csch_cfg_s         cfg_one_out,
   input wire logic                        sched_out_one_out,
   input wire logic                        sched_out_two_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   csch_pkg::csch_cfg_s c;
   logic                day_ok;
   assign c = cfg_one_out;
   assign day_ok = c.weekday_mask[cal_weekday_in] && cal_date_in >= c.on_date
      && (c.off_date < c.on_date || cal_date_in < c.off_date);
   chk_hold_one: assert property (!sec_tick_in |=> $stable(sched_out_one_out))
      else $error("output one moved without a tick");
   chk_hold_two: assert property (!sec_tick_in |=> $stable(sched_out_two_out))
      else $error("output two moved without a tick");
   chk_mask_gate: assert property (sec_tick_in && !c.weekday_mask[cal_weekday_in]
      |=> !sched_out_one_out) else $error("output on for a masked day");
   chk_before_on: assert property (sec_tick_in && cal_date_in < c.on_date
      |=> !sched_out_one_out) else $error("output on before the on-date");
   chk_after_off: assert property (sec_tick_in && c.off_date >= c.on_date
      && cal_date_in >= c.off_date |=> !sched_out_one_out) else $error("output on after off-date");
   chk_on_time: assert property (sec_tick_in && day_ok && cal_time_in == c.on_time
      |=> sched_out_one_out) else $error("output off at the on-time");
   chk_off_time: assert property (sec_tick_in && cal_time_in == c.off_time
      && c.off_time != c.on_time && c.off_time != {5'h17, 6'h3b, 6'h3b}
      |=> !sched_out_one_out) else $error("output on at the off-time");
   chk_reset_low: assert property ($rose(nrst_in)
      |-> (!sched_out_one_out && !sched_out_two_out) [*3]) else $error("output on after reset");
endmodule
bind csch_top csch_checker u_chk (.clk_in, .nrst_in, .sec_tick_in, .cal_time_in, .cal_date_in,
   .cal_weekday_in, .cfg_one_out, .sched_out_one_out, .sched_out_two_out);
`default_nettype wire

// ==== dv/csch_cal_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module csch_cal_model (
   input  wire logic                   clk_in,
   output var logic                    sec_tick_out,
   output var csch_pkg::csch_time_s    cal_time_out,
   output var csch_pkg::csch_date_s    cal_date_out,
   output var logic [2:0]              cal_weekday_out
);
   initial begin
      sec_tick_out = 1'h0;
      cal_time_out = '0;
      cal_date_out = '0;
      cal_weekday_out = 3'h0;
   end
   // The calendar is loaded with the tick so the schedulers never see a stale date.
   task automatic now(input csch_pkg::csch_time_s t, input csch_pkg::csch_date_s d,
                      input logic [2:0] w);
      @(posedge clk_in);
      sec_tick_out <= 1'h1;
      cal_time_out <= t;
      cal_date_out <= d;
      cal_weekday_out <= w;
      @(posedge clk_in);
      sec_tick_out <= 1'h0;
   endtask
endmodule
`default_nettype wire

// ==== dv/csch_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module csch_bench;
   localparam csch_pkg::csch_time_s T0 = 17'h0, T7 = {5'h07, 12'hefb}, T8 = {5'h08, 12'h0};
   localparam csch_pkg::csch_time_s T12 = {5'h0c, 12'h0}, T17 = {5'h11, 12'h0};
   localparam csch_pkg::csch_time_s TE = {5'h17, 6'h3b, 6'h3b};
   localparam csch_pkg::csch_date_s DON = {12'h7e1, 9'h41}, DOFF = {12'h833, 9'h19f};
   localparam csch_pkg::csch_date_s DM = {12'h7e4, 9'ha4}, DPRE = {12'h7e1, 9'h3f};
   localparam csch_pkg::csch_date_s DLT = {12'h834, 9'h24}, DOLD = {12'h7d0, 9'h21};
   logic clk_in, nrst_in, tick, we1, we2, out1, out2;
   logic [2:0] wd;
   csch_pkg::csch_time_s tn;
   csch_pkg::csch_date_s dn;
   csch_pkg::csch_cfg_s  cf1, cf2, rb1, rb2;
   int fail_count = 0;
   int checked = 0;
   csch_cal_model CAL (.clk_in(clk_in), .sec_tick_out(tick), .cal_time_out(tn),
      .cal_date_out(dn), .cal_weekday_out(wd));
   csch_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .sec_tick_in(tick), .cal_time_in(tn),
      .cal_date_in(dn), .cal_weekday_in(wd), .cfg_we_one_in(we1), .cfg_one_in(cf1),
      .cfg_we_two_in(we2), .cfg_two_in(cf2), .cfg_one_out(rb1), .cfg_two_out(rb2),
      .sched_out_one_out(out1), .sched_out_two_out(out2));
   initial begin
      clk_in = 1'h0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic summarize();
      if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [82:0] got, input logic [82:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic two, input csch_pkg::csch_cfg_s c);
      @(posedge clk_in);
      we1 <= !two;
      we2 <= two;
      cf1 <= c;
      cf2 <= c;
      @(posedge clk_in);
      we1 <= 1'h0;
      we2 <= 1'h0;
      #1 chk(two ? rb2 : rb1, c);
   endtask
   task automatic step(input csch_pkg::csch_time_s t, input csch_pkg::csch_date_s d,
                       input logic [2:0] w, input logic e1, input logic e2);
      CAL.now(t, d, w);
      #1 chk(out1, e1);
      chk(out2, e2);
   endtask
   initial begin
      nrst_in = 1'h0;
      {we1, we2, cf1, cf2} = '0;
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      #1 chk(rb1, csch_pkg::DEF_CFG);
      chk(rb2, csch_pkg::DEF_CFG);
      step(T12, DM, 3'h0, 1'h0, 1'h0);
      wr(1'h0, '{T8, T17, DON, DOFF, 7'h1f});
      wr(1'h1, '{T0, TE, DON, DOFF, 7'h60});
      step(T7, DM, 3'h0, 1'h0, 1'h0);
      step(T8, DM, 3'h0, 1'h1, 1'h0);
      step(T17, DM, 3'h0, 1'h0, 1'h0);
      step(T12, DM, 3'h5, 1'h0, 1'h1);
      step(TE, DM, 3'h6, 1'h0, 1'h1);
      step(T0, DM, 3'h6, 1'h0, 1'h1);
      step(T12, DM, 3'h7, 1'h0, 1'h0);
      step(T12, DPRE, 3'h0, 1'h0, 1'h0);
      step(T12, DOFF, 3'h0, 1'h0, 1'h0);
      wr(1'h0, '{T8, T17, DON, DOLD, 7'h1f});
      step(T12, DLT, 3'h0, 1'h1, 1'h0);
      repeat (5) @(posedge clk_in);
      chk(out1, 1'h1);
      summarize();
   end
   initial begin
      #20000;
      fail_count++;
      $display("ERROR %0t: watchdog expired", $time);
      summarize();
   end
endmodule
`default_nettype wire
